//--- core/mb_pkg.sv
package mb_pkg;

  // ************************************************
  // frame layout and buffer sizing
  // ************************************************
  localparam int HDR_BYTES = 7;
  localparam int DATA_DEPTH = 32;
  localparam int DATA_AW = 5;
  localparam logic [7:0] MIN_LEN = 8'h04;
  localparam logic [7:0] SINGLE_LEN = 8'h08;
  localparam logic [8:0] MULTI_OVERHEAD = 9'h009;
  localparam logic [2:0] RESP_LEN = 3'h6;
  localparam logic [2:0] EXC_LEN = 3'h3;

  // ************************************************
  // function and exception codes
  // ************************************************
  localparam logic [7:0] BROADCAST = 8'h00;
  localparam logic [7:0] FC_COIL = 8'h05;
  localparam logic [7:0] FC_REG = 8'h06;
  localparam logic [7:0] FC_LOOP = 8'h08;
  localparam logic [7:0] FC_COILS = 8'h0F;
  localparam logic [7:0] FC_REGS = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] EXC_BUSY = 8'h22;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] SUB_ECHO = 16'h0000;

  // ************************************************
  // map limits (highest item number, largest count)
  // ************************************************
  localparam logic [16:0] COIL_LAST = 17'h000FF;
  localparam logic [16:0] REG_LAST = 17'h03FFF;
  localparam logic [15:0] COIL_MAX_CNT = 16'h0020;
  localparam logic [15:0] REG_MAX_CNT = 16'h0010;

  // ************************************************
  // crc
  // ************************************************
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  typedef enum logic [2:0] {
    ST_RX = 3'b000,
    ST_CHECK = 3'b001,
    ST_RD = 3'b010,
    ST_USE = 3'b011,
    ST_TX = 3'b100
  } state_t;

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16_byte

endpackage : mb_pkg

//--- core/frame_ram.sv
module frame_ram (
  // clock
  input wire logic i_clock,
  input wire logic i_ce,
  // write port
  input wire logic i_we,
  input wire logic [mb_pkg::DATA_AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // read port, one cycle latency
  input wire logic [mb_pkg::DATA_AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);

  logic [7:0] mem_r [0:mb_pkg::DATA_DEPTH-1];

  always_ff @(posedge i_clock) begin
    if (i_ce && i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_ce) begin
      o_rdata <= mem_r[i_raddr];
    end
  end

endmodule : frame_ram

//--- core/modbus_slave_write_loopback.sv
// Summary of operation
// - broadcast queries for these functions are never answered nor executed.
// - item number addressed is the start field plus one.
// - function 05 writes one coil, echoes query, else exception.
// - function 06 stores change data in register, echoes query.
// - function 08 echoes address, function, subcode and data with crc.
// - loopback accepts only subcode 0000; others get a data exception.
// - function 0F writes consecutive coils, replies header without data.
// - data byte count must match the byte-count field, else frame dropped.
// - function 10 writes consecutive registers, high byte first, in order.
// - exception reply is function plus 80h, exception code, crc.
// - first packed coil maps to bit 0 of first data byte.
// - no reply to broadcast, error, other address, bad gap or length.
module modbus_slave_write_loopback (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_ce,
  // configuration
  input wire logic [7:0] i_slave_addr,
  input wire logic i_write_lock,
  // received frame from the character layer
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_error,
  input wire logic i_rx_end,
  // response bytes
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  // coil write port
  output logic o_coil_we,
  output logic [15:0] o_coil_addr,
  output logic o_coil_val,
  // holding register write port
  output logic o_reg_we,
  output logic [15:0] o_reg_addr,
  output logic [15:0] o_reg_data
);

  mb_pkg::state_t state_r;
  logic [7:0] hdr_r [0:mb_pkg::HDR_BYTES-1];
  logic [7:0] rx_cnt_r;
  logic [15:0] rx_crc_r;
  logic rx_err_r;
  logic rx_ovf_r;
  logic [7:0] exc_r;
  logic multi_coil_r;
  logic [4:0] idx_r;
  logic [4:0] end_idx_r;
  logic [7:0] hi_r;
  logic [2:0] tx_idx_r;
  logic [15:0] tx_crc_r;
  logic [7:0] rdata;
  logic drop;
  logic [7:0] exc_code;

  wire logic [7:0] slave = hdr_r[0];
  wire logic [7:0] fc = hdr_r[1];
  wire logic [15:0] start_field = {hdr_r[2], hdr_r[3]};
  wire logic [15:0] word2 = {hdr_r[4], hdr_r[5]};
  wire logic [7:0] byte_cnt = hdr_r[6];
  wire logic [16:0] start_item = {1'b0, start_field} + 17'h00001;
  wire logic [16:0] last_item = {1'b0, start_field} + {1'b0, word2};
  wire logic [2:0] tx_len = (exc_r != mb_pkg::EXC_NONE) ? mb_pkg::EXC_LEN : mb_pkg::RESP_LEN;
  wire logic [mb_pkg::DATA_AW-1:0] rx_waddr = mb_pkg::DATA_AW'(rx_cnt_r - 8'(mb_pkg::HDR_BYTES));
  wire logic rx_take = (state_r == mb_pkg::ST_RX) && i_rx_valid;
  wire logic rx_to_ram = rx_take && (rx_cnt_r >= 8'(mb_pkg::HDR_BYTES));
  wire logic tx_fire = (state_r == mb_pkg::ST_TX) && i_tx_ready;

  // response byte; exception replies swap in function flag and code
  function automatic logic [7:0] tx_byte(input logic [2:0] idx, input logic [15:0] crc);
    if (idx < tx_len) begin
      if (exc_r == mb_pkg::EXC_NONE) begin
        return hdr_r[idx];
      end else begin
        unique case (idx)
          3'h0: return slave;
          3'h1: return fc | mb_pkg::FC_EXC_FLAG;
          default: return exc_r;
        endcase
      end
    end else if (idx == tx_len) begin
      return crc[7:0];
    end else begin
      return crc[15:8];
    end
  endfunction : tx_byte

  // ************************************************
  // frame buffer for data bytes past the header
  // ************************************************
  frame_ram frame_ram_inst (
    .i_clock(i_clock),
    .i_ce(i_ce),
    .i_we(rx_to_ram && (rx_cnt_r < 8'(mb_pkg::HDR_BYTES + mb_pkg::DATA_DEPTH))),
    .i_waddr(rx_waddr),
    .i_wdata(i_rx_data),
    .i_raddr(multi_coil_r ? {3'h0, idx_r[4:3]} : idx_r),
    .o_rdata(rdata)
  );

  // ************************************************
  // query validation
  // ************************************************
  always_comb begin
    drop = 1'b0;
    exc_code = mb_pkg::EXC_NONE;
    if (rx_err_r || rx_cnt_r < mb_pkg::MIN_LEN) begin
      drop = 1'b1;
    end
    if (rx_crc_r != mb_pkg::CRC_GOOD) begin
      drop = 1'b1;
    end
    if (slave == mb_pkg::BROADCAST || slave != i_slave_addr) begin
      drop = 1'b1;
    end
    unique case (fc)
      mb_pkg::FC_COIL: begin
        if (rx_cnt_r != mb_pkg::SINGLE_LEN) drop = 1'b1;
        else if (word2 != mb_pkg::COIL_ON && word2 != mb_pkg::COIL_OFF) exc_code = mb_pkg::EXC_DATA;
        else if (start_item > mb_pkg::COIL_LAST) exc_code = mb_pkg::EXC_ADDR;
        else if (i_write_lock) exc_code = mb_pkg::EXC_BUSY;
      end
      mb_pkg::FC_REG: begin
        if (rx_cnt_r != mb_pkg::SINGLE_LEN) drop = 1'b1;
        else if (start_item > mb_pkg::REG_LAST) exc_code = mb_pkg::EXC_ADDR;
        else if (i_write_lock) exc_code = mb_pkg::EXC_BUSY;
      end
      mb_pkg::FC_LOOP: begin
        if (rx_cnt_r != mb_pkg::SINGLE_LEN) drop = 1'b1;
        else if (start_field != mb_pkg::SUB_ECHO) exc_code = mb_pkg::EXC_DATA;
      end
      mb_pkg::FC_COILS: begin
        if (rx_ovf_r || {1'b0, rx_cnt_r} != mb_pkg::MULTI_OVERHEAD + {1'b0, byte_cnt}) drop = 1'b1;
        else if (word2 == 16'h0000 || word2 > mb_pkg::COIL_MAX_CNT) exc_code = mb_pkg::EXC_DATA;
        else if (byte_cnt < 8'((word2 + 16'h0007) >> 3)) exc_code = mb_pkg::EXC_DATA;
        else if (last_item > mb_pkg::COIL_LAST) exc_code = mb_pkg::EXC_ADDR;
        else if (i_write_lock) exc_code = mb_pkg::EXC_BUSY;
      end
      mb_pkg::FC_REGS: begin
        if (rx_ovf_r || {1'b0, rx_cnt_r} != mb_pkg::MULTI_OVERHEAD + {1'b0, byte_cnt}) drop = 1'b1;
        else if (word2 == 16'h0000 || word2 > mb_pkg::REG_MAX_CNT) exc_code = mb_pkg::EXC_DATA;
        else if ({8'h00, byte_cnt} != (word2 << 1)) exc_code = mb_pkg::EXC_DATA;
        else if (last_item > mb_pkg::REG_LAST) exc_code = mb_pkg::EXC_ADDR;
        else if (i_write_lock) exc_code = mb_pkg::EXC_BUSY;
      end
      default: exc_code = mb_pkg::EXC_FUNC;
    endcase
  end

  // ************************************************
  // receive capture; ignored while a query is served
  // ************************************************
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rx_cnt_r <= 8'h00;
      rx_crc_r <= mb_pkg::CRC_INIT;
      rx_err_r <= 1'b0;
      rx_ovf_r <= 1'b0;
    end else if (i_ce) begin
      if (state_r == mb_pkg::ST_CHECK) begin
        rx_cnt_r <= 8'h00;
        rx_crc_r <= mb_pkg::CRC_INIT;
        rx_err_r <= 1'b0;
        rx_ovf_r <= 1'b0;
      end else if (state_r == mb_pkg::ST_RX) begin
        if (i_rx_error) rx_err_r <= 1'b1;
        if (i_rx_valid) begin
          if (rx_cnt_r != 8'hFF) rx_cnt_r <= rx_cnt_r + 8'h01;
          rx_crc_r <= mb_pkg::crc16_byte(rx_crc_r, i_rx_data);
          if (rx_to_ram && rx_cnt_r >= 8'(mb_pkg::MULTI_OVERHEAD) + 8'(mb_pkg::DATA_DEPTH)) rx_ovf_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      for (int i = 0; i < mb_pkg::HDR_BYTES; i++) hdr_r[i] <= 8'h00;
    end else if (i_ce && rx_take && rx_cnt_r < 8'(mb_pkg::HDR_BYTES)) begin
      hdr_r[rx_cnt_r[2:0]] <= i_rx_data;
    end
  end

  // ************************************************
  // sequencing
  // ************************************************
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r <= mb_pkg::ST_RX;
      exc_r <= mb_pkg::EXC_NONE;
      multi_coil_r <= 1'b0;
      end_idx_r <= 5'h00;
    end else if (i_ce) begin
      unique case (state_r)
        mb_pkg::ST_RX: begin
          if (i_rx_end && (rx_cnt_r != 8'h00 || i_rx_valid)) state_r <= mb_pkg::ST_CHECK;
        end
        mb_pkg::ST_CHECK: begin
          exc_r <= exc_code;
          multi_coil_r <= (fc == mb_pkg::FC_COILS);
          end_idx_r <= (fc == mb_pkg::FC_COILS) ? 5'(word2 - 16'h0001) : 5'((word2 << 1) - 16'h0001);
          if (drop) state_r <= mb_pkg::ST_RX;
          else if (exc_code == mb_pkg::EXC_NONE && (fc == mb_pkg::FC_COILS || fc == mb_pkg::FC_REGS)) begin
            state_r <= mb_pkg::ST_RD;
          end else state_r <= mb_pkg::ST_TX;
        end
        mb_pkg::ST_RD: state_r <= mb_pkg::ST_USE;
        mb_pkg::ST_USE: state_r <= (idx_r == end_idx_r) ? mb_pkg::ST_TX : mb_pkg::ST_RD;
        mb_pkg::ST_TX: begin
          if (i_tx_ready && tx_idx_r == tx_len + 3'h1) state_r <= mb_pkg::ST_RX;
        end
        default: state_r <= mb_pkg::ST_RX;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      idx_r <= 5'h00;
    end else if (i_ce) begin
      if (state_r == mb_pkg::ST_CHECK) idx_r <= 5'h00;
      else if (state_r == mb_pkg::ST_USE) idx_r <= idx_r + 5'h01;
    end
  end

  // ************************************************
  // write ports; writes happen only once the frame checked
  // ************************************************
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_coil_we <= 1'b0;
      o_coil_addr <= 16'h0000;
      o_coil_val <= 1'b0;
    end else if (i_ce) begin
      o_coil_we <= 1'b0;
      if (state_r == mb_pkg::ST_CHECK && !drop && exc_code == mb_pkg::EXC_NONE && fc == mb_pkg::FC_COIL) begin
        o_coil_we <= 1'b1;
        o_coil_addr <= start_item[15:0];
        o_coil_val <= (word2 == mb_pkg::COIL_ON);
      end else if (state_r == mb_pkg::ST_USE && multi_coil_r) begin
        o_coil_we <= 1'b1;
        o_coil_addr <= start_item[15:0] + {11'h000, idx_r};
        o_coil_val <= rdata[idx_r[2:0]];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_reg_we <= 1'b0;
      o_reg_addr <= 16'h0000;
      o_reg_data <= 16'h0000;
      hi_r <= 8'h00;
    end else if (i_ce) begin
      o_reg_we <= 1'b0;
      if (state_r == mb_pkg::ST_CHECK && !drop && exc_code == mb_pkg::EXC_NONE && fc == mb_pkg::FC_REG) begin
        o_reg_we <= 1'b1;
        o_reg_addr <= start_item[15:0];
        o_reg_data <= word2;
      end else if (state_r == mb_pkg::ST_USE && !multi_coil_r) begin
        if (!idx_r[0]) hi_r <= rdata;
        else begin
          // ascending order keeps the upper word of a wide value at the lower number
          o_reg_we <= 1'b1;
          o_reg_addr <= start_item[15:0] + {12'h000, idx_r[4:1]};
          o_reg_data <= {hi_r, rdata};
        end
      end
    end
  end

  // ************************************************
  // response transmit
  // ************************************************
  assign o_tx_valid = (state_r == mb_pkg::ST_TX);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tx_idx_r <= 3'h0;
      tx_crc_r <= mb_pkg::CRC_INIT;
      o_tx_data <= 8'h00;
    end else if (i_ce) begin
      if (state_r != mb_pkg::ST_TX) begin
        tx_idx_r <= 3'h0;
        tx_crc_r <= mb_pkg::CRC_INIT;
        o_tx_data <= slave;
      end else if (tx_fire) begin
        tx_idx_r <= tx_idx_r + 3'h1;
        if (tx_idx_r < tx_len) begin
          tx_crc_r <= mb_pkg::crc16_byte(tx_crc_r, o_tx_data);
          o_tx_data <= tx_byte(tx_idx_r + 3'h1, mb_pkg::crc16_byte(tx_crc_r, o_tx_data));
        end else begin
          o_tx_data <= tx_byte(tx_idx_r + 3'h1, tx_crc_r);
        end
      end
    end
  end

endmodule : modbus_slave_write_loopback

//--- dv/query_master.sv
module query_master (
  // clock
  input wire logic i_clock,
  // query stream toward the slave
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_error,
  output logic o_rx_end,
  // response stream from the slave
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] resp[$];
  logic slow = 1'b0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'hA5;
    o_rx_error = 1'b0;
    o_rx_end = 1'b0;
  end
  // ************************************************
  // framing
  // ************************************************
  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc_of
  // bytes go back to back; a broken crc or an error pulse only when asked for
  task automatic send(input logic [7:0] q[$], input logic bad, input logic err);
    logic [15:0] c;
    c = crc_of(q) ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(posedge i_clock);
      o_rx_valid <= 1'b1;
      o_rx_data <= q[i];
      o_rx_error <= err && (i == 2);
      o_rx_end <= (i == q.size() - 1);
    end
    @(posedge i_clock);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~q[q.size() - 1];
    o_rx_error <= 1'b0;
    o_rx_end <= 1'b0;
  endtask : send
  // slow mode drops ready every other cycle, so each byte can stall one cycle
  always @(posedge i_clock) begin
    if (i_tx_valid && o_tx_ready) resp.push_back(i_tx_data);
    o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
  end
endmodule : query_master

//--- dv/modbus_slave_write_loopback_asserts.sv
module modbus_slave_write_loopback_checker (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // query side
  input wire logic [7:0] i_slave_addr,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_error,
  input wire logic i_rx_end,
  // response and write side
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire logic o_coil_we,
  input wire logic [15:0] o_coil_addr,
  input wire logic o_reg_we,
  input wire logic [15:0] o_reg_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  logic in_frame_r;
  logic err_r;
  logic [7:0] addr_r;
  always_ff @(posedge i_clock) begin
    if (i_srst || i_rx_end) in_frame_r <= 1'b0;
    else if (i_rx_valid) in_frame_r <= 1'b1;
  end
  always_ff @(posedge i_clock) begin
    if (i_srst || i_rx_end) err_r <= 1'b0;
    else if (i_rx_error) err_r <= 1'b1;
  end
  // a one-byte frame would be missed here; such frames are too short anyway
  always_ff @(posedge i_clock) begin
    if (i_rx_valid && !in_frame_r) addr_r <= i_rx_data;
  end
  // ************************************************
  // assertions
  // ************************************************
  a_broadcast_silent: assert property (i_rx_end && addr_r == 8'h00 |=> (!o_tx_valid && !o_coil_we && !o_reg_we) [*3])
    else $error("broadcast query was answered or executed");
  a_foreign_silent: assert property (i_rx_end && addr_r != i_slave_addr |=> !o_tx_valid [*3])
    else $error("query for another slave was answered");
  a_error_drop: assert property (i_rx_end && (err_r || i_rx_error) |=> (!o_tx_valid && !o_reg_we) [*3])
    else $error("errored frame was not dropped");
  a_item_offset: assert property (o_coil_we |-> o_coil_addr != 16'h0000)
    else $error("coil zero written");
  a_coil_step: assert property (o_coil_we ##2 o_coil_we |-> o_coil_addr == $past(o_coil_addr, 2) + 16'h0001)
    else $error("consecutive coils not ascending");
  a_coil_pulse: assert property (o_coil_we |=> !o_coil_we)
    else $error("coil write pulse too long");
  a_reg_step: assert property (o_reg_we ##4 o_reg_we |-> o_reg_addr == $past(o_reg_addr, 4) + 16'h0001)
    else $error("consecutive registers not ascending");
  a_reg_spacing: assert property (o_reg_we |=> !o_reg_we [*3])
    else $error("register writes closer than four cycles");
  a_reply_address: assert property ($rose(o_tx_valid) |-> o_tx_data == i_slave_addr)
    else $error("response does not start with own address");
  a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("response byte changed while stalled");
endmodule : modbus_slave_write_loopback_checker

//--- dv/test_modbus_slave_write_loopback.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t: got %0h expected %0h", $time, (a), (b)); end end
module test_modbus_slave_write_loopback;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_srst, i_ce, i_write_lock, i_rx_valid, i_rx_error, i_rx_end, i_tx_ready;
  logic o_tx_valid, o_coil_we, o_coil_val, o_reg_we;
  logic [7:0] i_slave_addr, i_rx_data, o_tx_data;
  logic [15:0] o_coil_addr, o_reg_addr, o_reg_data;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] wlog[$];
  modbus_slave_write_loopback modbus_slave_write_loopback_inst (.*);
  query_master query_master_inst (.i_clock(i_clock), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
    .o_rx_error(i_rx_error), .o_rx_end(i_rx_end), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
    .o_tx_ready(i_tx_ready));
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // coils carry their value in bit 0
  always @(posedge i_clock) begin
    if (o_coil_we) wlog.push_back({o_coil_addr, 15'h0, o_coil_val});
    if (o_reg_we) wlog.push_back({o_reg_addr, o_reg_data});
  end
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // ************************************************
  // one query, reply compared byte for byte
  // ************************************************
  task automatic run(input logic [7:0] q[$], input logic [7:0] exc = 8'h00, input logic silent = 1'b0,
                     input logic bad = 1'b0, input logic err = 1'b0);
    logic [7:0] e[$];
    logic [15:0] c;
    int n;
    logic seen;
    wlog.delete();
    query_master_inst.resp.delete();
    if (exc != 8'h00) e = '{q[0], q[1] | mb_pkg::FC_EXC_FLAG, exc};
    else if (!silent) e = q[0:5];
    c = query_master_inst.crc_of(e);
    if (e.size() != 0) e = {e, c[7:0], c[15:8]};
    query_master_inst.send(q, bad, err);
    n = 0;
    seen = 1'b0;
    while (n < 100 && !(seen && !o_tx_valid)) begin
      @(posedge i_clock);
      #1;
      seen = seen | o_tx_valid;
      n++;
    end
    if (n == 100 && seen) begin
      err_count++;
      $display("ERROR %0t: response never ended", $time);
      test_done();
    end
    `CHK(query_master_inst.resp.size(), e.size())
    foreach (e[i]) `CHK(query_master_inst.resp[i], e[i])
    if (exc != 8'h00 || silent) `CHK(wlog.size(), 0)
  endtask : run
  task automatic t_coil;
    run('{8'h05, 8'h05, 8'h00, 8'h00, 8'hFF, 8'h00});
    `CHK(wlog[0], 32'h0001_0001)
    run('{8'h05, 8'h05, 8'h00, 8'hFE, 8'h00, 8'h00});
    `CHK(wlog[0], 32'h00FF_0000)
  endtask : t_coil
  task automatic t_reg;
    run('{8'h05, 8'h06, 8'h12, 8'h02, 8'h00, 8'h32});
    `CHK(wlog.size(), 1)
    `CHK(wlog[0], 32'h1203_0032)
  endtask : t_reg
  task automatic t_loop;
    run('{8'h05, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34});
    `CHK(wlog.size(), 0)
    run('{8'h05, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, mb_pkg::EXC_DATA);
  endtask : t_loop
  // six coils in one byte, padded to two bytes, with the reader stalling
  task automatic t_coils;
    query_master_inst.slow = 1'b1;
    run('{8'h05, 8'h0F, 8'h00, 8'h06, 8'h00, 8'h06, 8'h02, 8'h17, 8'h00});
    `CHK(wlog.size(), 6)
    for (int i = 0; i < 6; i++) `CHK(wlog[i], {16'h0007 + 16'(i), 15'h0, 1'(8'h17 >> i)})
    query_master_inst.slow = 1'b0;
  endtask : t_coils
  // second query fills the data buffer completely, crc bytes beyond it
  task automatic t_regs;
    logic [7:0] q[$];
    run('{8'h05, 8'h10, 8'h11, 8'h02, 8'h00, 8'h02, 8'h04, 8'h00, 8'h04, 8'h93, 8'hE0});
    `CHK(wlog.size(), 2)
    `CHK(wlog[0], 32'h1103_0004)
    `CHK(wlog[1], 32'h1104_93E0)
    q = '{8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h10, 8'h20};
    for (int i = 0; i < 16; i++) q = {q, 8'(i), 8'hC0};
    run(q);
    `CHK(wlog.size(), 16)
    `CHK(wlog[15], 32'h0010_0FC0)
  endtask : t_regs
  task automatic t_except;
    run('{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, mb_pkg::EXC_FUNC);
    run('{8'h05, 8'h05, 8'h00, 8'h00, 8'h12, 8'h34}, mb_pkg::EXC_DATA);
    run('{8'h05, 8'h06, 8'h3F, 8'hFF, 8'h00, 8'h01}, mb_pkg::EXC_ADDR);
    @(posedge i_clock);
    i_write_lock <= 1'b1;
    run('{8'h05, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01}, mb_pkg::EXC_BUSY);
    @(posedge i_clock);
    i_write_lock <= 1'b0;
  endtask : t_except
  task automatic t_drop;
    run('{8'h00, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01}, 8'h00, 1'b1);
    run('{8'h07, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01}, 8'h00, 1'b1);
    run('{8'h05, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01}, 8'h00, 1'b1, 1'b1);
    run('{8'h05, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01}, 8'h00, 1'b1, 1'b0, 1'b1);
    run('{8'h05, 8'h0F, 8'h00, 8'h06, 8'h00, 8'h06, 8'h03, 8'h17, 8'h00}, 8'h00, 1'b1);
  endtask : t_drop
  initial begin
    i_srst = 1'b1;
    i_ce = 1'b1;
    i_slave_addr = 8'h05;
    i_write_lock = 1'b0;
    repeat (2) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
    t_coil();
    t_reg();
    t_loop();
    t_coils();
    t_regs();
    t_except();
    t_drop();
    test_done();
  end
endmodule : test_modbus_slave_write_loopback
bind modbus_slave_write_loopback modbus_slave_write_loopback_checker modbus_slave_write_loopback_checker_inst (.*);
